/* File: fhri_top.sv */
`timescale 1ns/10ps
module fhri_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic csN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic registerSelect,
	input wire logic [fhri_pkg::DATA_W-1:0] dbIn,
	output logic [fhri_pkg::DATA_W-1:0] dbOut,
	output logic dbOe,
	output logic intReq,
	output logic drq,
	input wire logic dackN,
	input wire logic tc,
	output logic tcSeen,
	input wire logic drive0SeekActive,
	input wire logic drive1SeekActive,
	input wire logic drive2SeekActive,
	input wire logic drive3SeekActive,
	input wire logic execActive,
	input wire logic execDma,
	input wire logic hostReadDir,
	output logic toCoreValid,
	input wire logic toCoreReady,
	output logic [fhri_pkg::DATA_W-1:0] toCoreData,
	input wire logic fromCoreValid,
	output logic fromCoreReady,
	input wire logic [fhri_pkg::DATA_W-1:0] fromCoreData
);
	import fhri_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] dbOut;
		logic dbOe;
		logic [DATA_W-1:0] status;
		logic [DATA_W-1:0] holdData;
		logic holdValid;
		logic [DATA_W-1:0] wrData;
		logic [DATA_W-1:0] pushData;
		logic push;
		logic [DATA_W-1:0] toCoreData;
		logic toCoreValid;
		logic fromCoreReady;
		logic intReq;
		logic drq;
		logic tcSeen;
		logic tcPrev;
		logic rdPrev;
		logic wrPrev;
		logic rdIsData;
	} fhri_top_t;

	fhri_top_t st;
	fhri_top_t next_st;

	logic [PIN_W-1:0] pinsRaw;
	logic [PIN_W-1:0] pins;
	logic [DATA_W-1:0] busByte;
	logic [DATA_W-1:0] liveStatus;
	logic [SEEK_N-1:0] seekVec;
	logic hostSel;
	logic dmaExec;
	logic pioExec;
	logic dmaSel;
	logic rdOnly;
	logic wrOnly;
	logic dataPath;
	logic rdAct;
	logic wrAct;
	logic rdStart;
	logic rdEnd;
	logic wrStart;
	logic wrEnd;
	logic statusRdStart;
	logic dataRdStart;
	logic dataRdEnd;
	logic statusWr;
	logic rqmNow;
	logic intSet;
	logic intClr;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoOutReady;
	logic [DATA_W-1:0] fifoOutData;

	assign pinsRaw = {csN, rdN, wrN, registerSelect, dackN, tc, dbIn};

	fhri_sync #(
		.W(PIN_W),
		.IDLE(PIN_IDLE)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.din(pinsRaw),
		.dout(pins)
	);

	// host bytes queue here so a slow core does not lose a burst of parameters
	fhri_fifo #(
		.W(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.inValid(st.push),
		.inReady(fifoInReady),
		.inData(st.pushData),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData)
	);

	assign busByte = pins[PIN_DB+DATA_W-1:PIN_DB];
	assign seekVec = {drive3SeekActive, drive2SeekActive, drive1SeekActive, drive0SeekActive};
	assign hostSel = ~pins[PIN_CS]; // R17
	assign dmaExec = execActive & execDma;
	assign pioExec = execActive & ~execDma;
	assign dmaSel = ~pins[PIN_DACK] & dmaExec;
	// both strobes low at once is treated as no access at all
	assign rdOnly = ~pins[PIN_RD] & pins[PIN_WR]; // R08
	assign wrOnly = ~pins[PIN_WR] & pins[PIN_RD]; // R08
	// the host loses the data path while the DMA controller owns execution
	assign dataPath = dmaSel | (hostSel & pins[PIN_SEL] & ~dmaExec); // R15
	assign rdAct = rdOnly & (dataPath | (hostSel & ~pins[PIN_SEL])); // R05 R06
	// a write with select at 0 matches nothing and is dropped unless acknowledge is low in DMA execution
	assign wrAct = wrOnly & dataPath; // R02 R07
	assign statusWr = hostSel & ~pins[PIN_SEL] & wrOnly;
	assign rdStart = rdAct & ~st.rdPrev;
	assign rdEnd = ~rdAct & st.rdPrev;
	assign wrStart = wrAct & ~st.wrPrev;
	assign wrEnd = ~wrAct & st.wrPrev;
	assign statusRdStart = rdStart & ~dataPath;
	assign dataRdStart = rdStart & dataPath;
	assign dataRdEnd = rdEnd & st.rdIsData;

	// a pending push is counted as taken, so ready never promises a slot twice
	assign rqmNow = hostReadDir ? st.holdValid : (fifoInReady & ~st.push); // R13
	assign fifoOutReady = fifoOutValid & (~st.toCoreValid | toCoreReady);

	always_comb begin
		liveStatus = STATUS_RESET;
		liveStatus[ST_SEEK+SEEK_N-1:ST_SEEK] = seekVec; // R09
		liveStatus[ST_PIO] = pioExec; // R10 R11
		liveStatus[ST_DIR] = hostReadDir; // R12
		liveStatus[ST_RDY] = rqmNow & ~dmaExec; // R13 R15
	end

	// a byte becomes due on a rising ready, or on entry to a non-DMA execution
	assign intSet = pioExec & rqmNow & (~st.status[ST_RDY] | ~st.status[ST_PIO]); // R14
	assign intClr = dataRdStart | (wrStart & dataPath) | ~pioExec;

	always_comb begin
		next_st = st;
		next_st.push = 1'b0;
		next_st.fromCoreReady = 1'b0;
		next_st.tcSeen = 1'b0;
		next_st.rdPrev = rdAct;
		next_st.wrPrev = wrAct;
		next_st.tcPrev = pins[PIN_TC];
		next_st.status = liveStatus; // R01
		if (rdStart) begin
			next_st.rdIsData = dataPath;
		end
		if (rdAct) begin
			next_st.dbOe = 1'b1;
			if (rdStart) begin
				next_st.dbOut = dataPath ? st.holdData : st.status; // R05 R06
			end else if (!st.rdIsData) begin
				// a long status read keeps following the live state
				next_st.dbOut = st.status; // R01
			end
		end else begin
			next_st.dbOe = 1'b0; // R17
		end
		if (wrAct) begin
			next_st.wrData = busByte;
		end
		// the byte is taken at the trailing edge, when the host data has settled
		if (wrEnd) begin
			next_st.push = 1'b1; // R04 R07 R16
			next_st.pushData = st.wrData;
		end
		if (dataRdEnd) begin
			next_st.holdValid = 1'b0; // R03 R04
		end
		if (!st.holdValid && fromCoreValid && !st.fromCoreReady) begin
			next_st.holdData = fromCoreData; // R03
			next_st.holdValid = 1'b1;
			next_st.fromCoreReady = 1'b1;
		end
		if (fifoOutReady) begin
			next_st.toCoreValid = 1'b1;
			next_st.toCoreData = fifoOutData;
		end else if (toCoreReady) begin
			next_st.toCoreValid = 1'b0;
		end
		next_st.drq = dmaExec & rqmNow & ~(dmaSel & (rdOnly | wrOnly)) & ~rdEnd & ~wrEnd; // R15
		next_st.intReq = intSet | (st.intReq & ~intClr); // R14
		next_st.tcSeen = pins[PIN_TC] & ~st.tcPrev & dmaSel;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dbOut = st.dbOut;
	assign dbOe = st.dbOe;
	assign intReq = st.intReq;
	assign drq = st.drq;
	assign tcSeen = st.tcSeen;
	assign toCoreValid = st.toCoreValid;
	assign toCoreData = st.toCoreData;
	assign fromCoreReady = st.fromCoreReady;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence idleBus;
		!(rdAct || wrAct) ##1 !(rdAct || wrAct);
	endsequence

	sequence hostDataRdInDma;
		hostSel && pins[PIN_SEL] && rdOnly && dmaExec && !dmaSel;
	endsequence

	sequence dataWrite;
		wrStart ##1 wrAct;
	endsequence

	status_read_a: assert property ( // R05
		statusRdStart |=> st.dbOe && st.dbOut == $past(st.status)
	) else $error("status read did not drive the status byte");

	status_live_a: assert property ( // R01
		rdAct && !rdStart && !st.rdIsData ##1 rdAct |-> st.dbOut == $past(st.status)
	) else $error("held status read stopped following state");

	data_read_a: assert property ( // R06
		dataRdStart |=> st.dbOe && st.dbOut == $past(st.holdData)
	) else $error("data read did not drive the presented byte");

	stack_pop_a: assert property ( // R03
		dataRdEnd && !$past(dataRdEnd) |=> !st.holdValid || st.fromCoreReady
	) else $error("presented byte not released after its read");

	write_push_a: assert property ( // R07
		wrEnd |=> st.push && st.pushData == $past(st.wrData)
	) else $error("data write not pushed toward the core");

	write_sample_a: assert property ( // R04
		dataWrite |=> st.wrData == $past(busByte)
	) else $error("write byte not sampled from the bus");

	status_ro_a: assert property ( // R02
		statusWr |=> !st.push ##1 !st.push
	) else $error("write to the status location was accepted");

	seek_bits_a: assert property ( // R09
		##1 st.status[ST_SEEK+SEEK_N-1:ST_SEEK] == $past(seekVec)
	) else $error("seek bits do not follow the drives");

	pio_bit_a: assert property ( // R10
		!$past(execActive) || $past(execDma) |-> !st.status[ST_PIO]
	) else $error("non-DMA bit set outside non-DMA execution");

	pio_end_a: assert property ( // R11
		$past(pioExec) && !pioExec |=> $fell(st.status[ST_PIO])
	) else $error("non-DMA bit did not fall at end of execution");

	dir_bit_a: assert property ( // R12
		##1 st.status[ST_DIR] == $past(hostReadDir)
	) else $error("direction bit wrong");

	ready_dma_a: assert property ( // R13
		dmaExec [*2] |-> !st.status[ST_RDY]
	) else $error("host ready shown during DMA execution");

	irq_pio_a: assert property ( // R14
		$rose(st.intReq) |-> $past(pioExec) && $past(rqmNow)
	) else $error("interrupt raised without a due non-DMA byte");

	irq_byte_a: assert property ( // R14
		intSet |=> st.intReq
	) else $error("due byte did not raise an interrupt");

	dma_block_a: assert property ( // R15
		hostDataRdInDma |=> !st.dbOe
	) else $error("host data read served during DMA execution");

	no_select_a: assert property ( // R17
		!hostSel && !dmaSel ##1 !hostSel && !dmaSel |-> !st.dbOe
	) else $error("bus driven without a select");

	idle_undriven_a: assert property ( // R17
		idleBus |-> !st.dbOe
	) else $error("bus driven with no read in progress");

	sequence coreOffer;
		!st.holdValid && fromCoreValid && !st.fromCoreReady;
	endsequence

	hold_take_a: assert property ( // R03
		coreOffer |=> st.holdValid && st.holdData == $past(fromCoreData)
	) else $error("offered byte not taken into the data stack");

	hold_keep_a: assert property ( // R03
		st.holdValid && !dataRdEnd |=> st.holdValid && $stable(st.holdData)
	) else $error("presented byte changed before it was read");

	core_feed_a: assert property ( // R04
		fifoOutReady |=> st.toCoreValid && st.toCoreData == $past(fifoOutData)
	) else $error("queued byte not handed to the core");

	push_single_a: assert property ( // R07
		st.push |=> !st.push
	) else $error("one write pushed more than one byte");

	write_undriven_a: assert property ( // R07
		wrAct |=> !st.dbOe
	) else $error("bus driven during a write");

	read_release_a: assert property ( // R17
		rdEnd |=> !st.dbOe
	) else $error("bus still driven after the read ended");

	ready_full_a: assert property ( // R13
		!hostReadDir && !fifoInReady |=> !st.status[ST_RDY]
	) else $error("ready shown with no room for a host byte");

	ready_held_a: assert property ( // R13
		hostReadDir && st.holdValid && !dmaExec |=> st.status[ST_RDY]
	) else $error("ready not shown with a byte presented");

	irq_leave_a: assert property ( // R14
		!pioExec |=> !st.intReq
	) else $error("interrupt held outside non-DMA execution");

	drq_dma_a: assert property ( // R15
		!dmaExec |=> !st.drq
	) else $error("DMA request outside DMA execution");

	tc_pulse_a: assert property ( // R15
		st.tcSeen |=> !st.tcSeen
	) else $error("terminal count pulse longer than one cycle");
endmodule : fhri_top

/* File: fhri_pkg.sv */
// Operation
// [R01] The 8-bit main status register can be read at any moment, in any command phase.
// [R02] The main status register is read-only and a write aimed at it changes nothing.
// [R03] The data location is a stack of byte registers with one byte presented at a time.
// [R04] Commands are written into the data location and results are read back from it.
// [R05] Select 0 with only the read strobe low drives the main status onto the bus.
// [R06] Select 1 with only the read strobe low drives the presented stack byte onto the bus.
// [R07] Select 1 with only the write strobe low captures the bus byte into the stack.
// [R08] The host never lowers both strobes together nor writes with select at 0.
// [R09] Status bits 0 to 3 are set while drives 0 to 3 are each seeking.
// [R10] Status bit 5 is set only during an execution phase in non-DMA mode.
// [R11] Status bit 5 clears when the non-DMA execution phase ends.
// [R12] Status bit 6 reads 1 for a transfer toward the host and 0 for one from the host.
// [R13] Status bit 7 says the data register is ready and the host checks it with bit 6.
// [R14] In non-DMA mode an interrupt request is raised for every data byte moved.
// [R15] In DMA mode the host only loads commands and the DMA controller moves execution bytes.
// [R16] Commands are multi-byte sequences of 8-bit values written through the data location.
// [R17] With chip select high the strobes are ignored and the data bus is not driven; the code still honours them while acknowledge is low in DMA execution.
package fhri_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int SEEK_N = 4;
	localparam int PIN_W = 14;
	localparam int PIN_CS = 13;
	localparam int PIN_RD = 12;
	localparam int PIN_WR = 11;
	localparam int PIN_SEL = 10;
	localparam int PIN_DACK = 9;
	localparam int PIN_TC = 8;
	localparam int PIN_DB = 0;
	// chip select, strobes and acknowledge idle high, the rest low
	localparam logic [PIN_W-1:0] PIN_IDLE = 14'h3A00;
	localparam int ST_SEEK = 0;
	localparam int ST_PIO = 5;
	localparam int ST_DIR = 6;
	localparam int ST_RDY = 7;
	localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
endpackage : fhri_pkg

/* File: fhri_sync.sv */
`timescale 1ns/10ps
module fhri_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] IDLE = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} fhri_sync_t;

	fhri_sync_t st;
	fhri_sync_t next_st;
	logic [W-1:0] agreed;

	// a bit moves only once the second and third stages match, so a one-cycle glitch never lands
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign agreed[i] = (st.s2[i] == st.s3[i]) ? st.s2[i] : st.q[i];
		end
	endgenerate

	always_comb begin
		next_st = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.q = agreed;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= {IDLE, IDLE, IDLE, IDLE};
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.q;
endmodule : fhri_sync

/* File: fhri_fifo.sv */
`timescale 1ns/10ps
module fhri_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] count;
	} fhri_fifo_t;

	fhri_fifo_t st;
	fhri_fifo_t next_st;
	logic doPush;
	logic doPop;

	assign inReady = st.count != FULL;
	assign outValid = st.count != '0;
	assign outData = st.mem[st.rp];
	assign doPush = inValid & inReady;
	assign doPop = outValid & outReady;

	always_comb begin
		next_st = st;
		if (doPush) begin
			next_st.mem[st.wp] = inData;
			next_st.wp = (st.wp == LAST) ? '0 : st.wp + 1'b1;
		end
		if (doPop) begin
			next_st.rp = (st.rp == LAST) ? '0 : st.rp + 1'b1;
		end
		next_st.count = st.count + CW'(doPush) - CW'(doPop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : fhri_fifo

/* File: fhri_core_model.sv */
`timescale 1ns/10ps
module fhri_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic stall,
	input wire logic toCoreValid,
	input wire logic [7:0] toCoreData,
	output logic toCoreReady,
	input wire logic offer,
	input wire logic [7:0] offerData,
	input wire logic fromCoreReady,
	output logic fromCoreValid,
	output logic [7:0] fromCoreData
);
	logic [7:0] got[$];
	logic [1:0] pace;
	// taking only every other cycle keeps back pressure on the output stage
	assign toCoreReady = !stall && pace[0];
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pace <= 2'h0;
			fromCoreValid <= 1'b0;
			fromCoreData <= 8'h00;
		end else begin
			pace <= pace + 2'h1;
			if (toCoreValid && toCoreReady) begin
				got.push_back(toCoreData);
			end
			if (offer) begin
				fromCoreValid <= 1'b1;
				fromCoreData <= offerData;
			end else if (fromCoreValid && fromCoreReady) begin
				// a released byte must not linger on the lines
				fromCoreValid <= 1'b0;
				fromCoreData <= ~fromCoreData;
			end
		end
	end
endmodule : fhri_core_model

/* File: tb_fhri_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; \
	$display("FAIL %s exp %h got %h", n, e, a); end end
module tb_fhri_top;
	import fhri_pkg::*;
	logic clk, rst, csN, rdN, wrN, registerSelect, dackN, tc, tcArm, stall, offer;
	logic execActive, execDma, hostReadDir, dbOe, intReq, drq, tcSeen, oe;
	logic toCoreValid, toCoreReady, fromCoreValid, fromCoreReady;
	logic [3:0] seek;
	logic [7:0] dbIn, dbOut, toCoreData, fromCoreData, offerData, q, e;
	logic [7:0] xq[$];
	int mismatches = 0;
	int compares = 0;
	int seed = 26270;
	int i;
	int tcHits = 0;
	fhri_top i_fhri_top (.clk(clk), .rst(rst), .csN(csN), .rdN(rdN), .wrN(wrN),
		.registerSelect(registerSelect), .dbIn(dbIn), .dbOut(dbOut), .dbOe(dbOe),
		.intReq(intReq), .drq(drq), .dackN(dackN), .tc(tc), .tcSeen(tcSeen),
		.drive0SeekActive(seek[0]), .drive1SeekActive(seek[1]),
		.drive2SeekActive(seek[2]), .drive3SeekActive(seek[3]),
		.execActive(execActive), .execDma(execDma), .hostReadDir(hostReadDir),
		.toCoreValid(toCoreValid), .toCoreReady(toCoreReady), .toCoreData(toCoreData),
		.fromCoreValid(fromCoreValid), .fromCoreReady(fromCoreReady),
		.fromCoreData(fromCoreData));
	fhri_core_model i_fhri_core_model (.clk(clk), .rst(rst), .stall(stall),
		.toCoreValid(toCoreValid), .toCoreData(toCoreData), .toCoreReady(toCoreReady),
		.offer(offer), .offerData(offerData), .fromCoreReady(fromCoreReady),
		.fromCoreValid(fromCoreValid), .fromCoreData(fromCoreData));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// terminal count follows the acknowledge one edge later while armed
	always @(posedge clk) begin
		tc <= tcArm & ~dackN;
		if (tcSeen === 1'b1) begin
			tcHits++;
		end
	end
	function automatic logic [7:0] st(input logic rdy);
		return {rdy, hostReadDir, execActive & ~execDma, 1'b0, seek};
	endfunction : st
	// strobes held 8 cycles, released 8: above the synchroniser and filter delay
	task automatic acc(input logic c, input logic s, input logic r, input logic w,
		input logic dk, input logic [7:0] d);
		@(posedge clk);
		csN <= c;
		registerSelect <= s;
		rdN <= r;
		wrN <= w;
		dackN <= dk;
		dbIn <= d;
		repeat (7) @(posedge clk);
		#1;
		q = dbOut;
		oe = dbOe;
		@(posedge clk);
		csN <= 1'b1;
		rdN <= 1'b1;
		wrN <= 1'b1;
		dackN <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : acc
	task automatic wr_data(input logic [7:0] d);
		acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, d);
		xq.push_back(d);
	endtask : wr_data
	task automatic chk_q();
		for (i = 0; i < 200 && i_fhri_core_model.got.size() < xq.size(); i++) begin
			@(posedge clk);
		end
		`CHK("byte count", xq.size(), i_fhri_core_model.got.size())
		for (i = 0; i < xq.size() && i < i_fhri_core_model.got.size(); i++) begin
			`CHK("byte", xq[i], i_fhri_core_model.got[i])
		end
	endtask : chk_q
	task automatic end_sim();
		if (mismatches == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	initial begin
		rst = 1'b1;
		{csN, rdN, wrN, registerSelect, dackN} = 5'h1F;
		{tcArm, stall, offer, execActive, execDma, hostReadDir} = 6'h00;
		seek = 4'h0;
		dbIn = 8'h00;
		offerData = 8'h00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("dbOe reset", 1'b0, dbOe)
		`CHK("drq reset", 1'b0, drq)
		for (i = 0; i < 12; i++) begin
			@(posedge clk);
			seek <= 4'($random(seed));
			execActive <= 1'($random(seed));
			execDma <= 1'($random(seed));
			hostReadDir <= 1'($random(seed));
			acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
			e = st(!hostReadDir && !(execActive && execDma));
			`CHK("status", e, q)
			`CHK("status oe", 1'b1, oe)
		end
		@(posedge clk);
		{execActive, execDma, hostReadDir} <= 3'h0;
		seek <= 4'hF;
		acc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
		`CHK("deselected oe", 1'b0, oe)
		acc(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h5A);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
		`CHK("status after write", st(1'b1), q)
		// core stalled: eight in the buffer, one in the output stage, the tenth is lost
		stall <= 1'b1;
		for (int k = 0; k < 10; k++) begin
			wr_data(8'($random(seed)));
		end
		void'(xq.pop_back());
		acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
		`CHK("status full", st(1'b0), q)
		stall <= 1'b0;
		chk_q();
		hostReadDir <= 1'b1;
		offerData <= 8'($random(seed));
		offer <= 1'b1;
		@(posedge clk);
		offer <= 1'b0;
		repeat (4) @(posedge clk);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
		`CHK("status held", st(1'b1), q)
		acc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
		`CHK("data read", offerData, q)
		acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
		`CHK("status drained", st(1'b0), q)
		hostReadDir <= 1'b0;
		execActive <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("int entry", 1'b1, intReq)
		wr_data(8'hA5);
		`CHK("int next byte", 1'b1, intReq)
		acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
		`CHK("status pio", st(1'b1), q)
		execActive <= 1'b0;
		acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
		`CHK("status pio end", st(1'b1), q)
		`CHK("int end", 1'b0, intReq)
		execActive <= 1'b1;
		execDma <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("drq", 1'b1, drq)
		acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'h11);
		acc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
		`CHK("dma host read oe", 1'b0, oe)
		tcArm <= 1'b1;
		acc(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'hC3);
		tcArm <= 1'b0;
		xq.push_back(8'hC3);
		`CHK("tc seen", 1, tcHits)
		acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
		`CHK("status dma", st(1'b0), q)
		`CHK("int dma", 1'b0, intReq)
		execActive <= 1'b0;
		chk_q();
		end_sim();
	end
endmodule : tb_fhri_top
